// ==== rtl/ccs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"

module ccs_host (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Serial link
	ccs_if.master            bus,
	// Configuration to the device
	output logic             i2c_en_o
);
	import ccs_pkg::*;

	// ****************************************
	// Pins and divider
	// ****************************************
	logic sda_s;

	ccs_pin_sync u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.scl_i   (bus.scl),
		.sda_i   (bus.sda),
		.scl_o   (),
		.sda_o   (sda_s),
		.scl_q_o (),
		.sda_q_o ()
	);

	localparam logic [6:0] QTR_LAST = 7'(`CCS_SCL_QTR_CYC - 1);

	ccs_hst_t    hst_r, hst_nxt;
	ccs_hph_t    ph_r, ph_nxt;
	logic [6:0]  dv_r;
	logic [1:0]  q_r, q_nxt;
	logic [3:0]  bit_r, bit_nxt;
	logic [7:0]  sh_r, sh_nxt;
	logic [1:0]  dcnt_r, dcnt_nxt;
	logic        last_r, last_nxt;
	logic        scl_oe_n_r, scl_oe_n_nxt;
	logic        sda_oe_n_r, sda_oe_n_nxt;
	logic        nack_r, nack_nxt;
	logic        done_r, done_nxt;
	logic [7:0]  rcnt_r, rcnt_nxt;
	logic [15:0] rdat_r, rdat_nxt;
	logic [1:0]  op_r;
	logic        i2c_en_r;
	logic [1:0]  len_r;
	logic [6:0]  hidx_r;
	logic [15:0] wd_r;
	logic        ack_r;
	logic [31:0] dat_r;

	// ****************************************
	// Bus decode
	// ****************************************
	wire        busy    = (hst_r != H_IDLE);
	wire        wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
	// Writes land at the edge where the master sees ack
	wire        wr      = wb_cyc_i & wb_stb_i & ack_r & wb_we_i;
	wire [1:0]  word    = wb_adr_i[3:2];
	wire        wr_ctrl = wr & (word == `CCS_WB_CTRL) & ~busy;
	wire        go      = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CCS_CTRL_GO];
	wire        wr_wd   = wr & (word == `CCS_WB_WDATA);
	wire [31:0] ctrl_rd = {17'h0, hidx_r, 2'h0, len_r, i2c_en_r, op_r, 1'b0};
	wire [31:0] rd_mux  = (word == `CCS_WB_CTRL)  ? ctrl_rd :
	                      (word == `CCS_WB_WDATA) ? {16'h0, wd_r} :
	                      (word == `CCS_WB_STAT)  ? {29'h0, done_r, nack_r, busy} :
	                                                {8'h0, rcnt_r, rdat_r};
	wire        blk     = op_r[1];
	wire        op_rd   = op_r[0];
	wire        rd_ph   = (ph_r == HP_RCNT) || (ph_r == HP_RDATA);
	wire [7:0]  cmd     = blk ? 8'h00 : {1'b1, hidx_r};
	wire        tick    = (dv_r == QTR_LAST);
	wire [1:0]  dcnt_p1 = dcnt_r + 2'h1;

	// ****************************************
	// Bit engine
	// ****************************************
	always_comb
	begin
		hst_nxt = hst_r;
		ph_nxt = ph_r;
		q_nxt = q_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		dcnt_nxt = dcnt_r;
		last_nxt = last_r;
		scl_oe_n_nxt = scl_oe_n_r;
		sda_oe_n_nxt = sda_oe_n_r;
		nack_nxt = nack_r;
		done_nxt = done_r;
		rcnt_nxt = rcnt_r;
		rdat_nxt = rdat_r;
		if (go)
		begin
			hst_nxt = H_START;
			ph_nxt = HP_ADDRW;
			q_nxt = 2'h0;
			sh_nxt = `CCS_ADDR_W;
			dcnt_nxt = 2'h0;
			nack_nxt = 1'b0;
			done_nxt = 1'b0;
		end
		else if (tick && busy)
		begin
			q_nxt = q_r + 2'h1;
			unique case (hst_r)
				H_IDLE:
				begin
					q_nxt = 2'h0;
				end
				H_START:
				begin
					// Serves start and repeated start alike
					if (q_r == 2'h0) scl_oe_n_nxt = 1'b0;
					if (q_r == 2'h1) sda_oe_n_nxt = 1'b1;
					if (q_r == 2'h2) scl_oe_n_nxt = 1'b1;
					if (q_r == 2'h3)
					begin
						sda_oe_n_nxt = 1'b0;
						hst_nxt = H_BYTE;
						bit_nxt = 4'h0;
					end
				end
				H_STOP:
				begin
					if (q_r == 2'h0) scl_oe_n_nxt = 1'b0;
					if (q_r == 2'h1) sda_oe_n_nxt = 1'b0;
					if (q_r == 2'h2) scl_oe_n_nxt = 1'b1;
					if (q_r == 2'h3)
					begin
						sda_oe_n_nxt = 1'b1;
						hst_nxt = H_IDLE;
						done_nxt = 1'b1;
					end
				end
				H_BYTE:
				begin
					if (q_r == 2'h0) scl_oe_n_nxt = 1'b0;
					if (q_r == 2'h1)
					begin
						if (bit_r != 4'h8)
							sda_oe_n_nxt = rd_ph | sh_r[7];
						else
							sda_oe_n_nxt = ~rd_ph | last_r;
					end
					if (q_r == 2'h2) scl_oe_n_nxt = 1'b1;
					if ((q_r == 2'h3) && (bit_r != 4'h8))
					begin
						sh_nxt = {sh_r[6:0], sda_s};
						bit_nxt = bit_r + 4'h1;
					end
					else if (q_r == 2'h3)
					begin
						bit_nxt = 4'h0;
						if (!rd_ph && sda_s)
						begin
							nack_nxt = 1'b1;
							hst_nxt = H_STOP;
						end
						else
						begin
							unique case (ph_r)
								HP_ADDRW:
								begin
									ph_nxt = HP_CMD;
									sh_nxt = cmd;
								end
								HP_CMD:
								begin
									sh_nxt = wd_r[7:0];
									ph_nxt = HP_WDATA;
									if (op_rd)
									begin
										hst_nxt = H_START;
										ph_nxt = HP_ADDRR;
										sh_nxt = `CCS_ADDR_R;
									end
									else if (blk && !i2c_en_r)
									begin
										ph_nxt = HP_CNT;
										sh_nxt = {6'h0, len_r};
									end
									else if (blk && (len_r == 2'h0))
									begin
										hst_nxt = H_STOP;
									end
								end
								HP_CNT:
								begin
									ph_nxt = HP_WDATA;
									sh_nxt = wd_r[7:0];
									if (len_r == 2'h0) hst_nxt = H_STOP;
								end
								HP_WDATA:
								begin
									dcnt_nxt = dcnt_p1;
									sh_nxt = wd_r[15:8];
									if (!blk || (dcnt_p1 == len_r))
										hst_nxt = H_STOP;
								end
								HP_ADDRR:
								begin
									ph_nxt = blk ? HP_RCNT : HP_RDATA;
									last_nxt = ~blk | (len_r == 2'h0);
								end
								HP_RCNT:
								begin
									rcnt_nxt = sh_r;
									ph_nxt = HP_RDATA;
									last_nxt = (len_r == 2'h1);
									if (last_r) hst_nxt = H_STOP;
								end
								HP_RDATA:
								begin
									if (dcnt_r == 2'h0) rdat_nxt[7:0] = sh_r;
									if (dcnt_r == 2'h1) rdat_nxt[15:8] = sh_r;
									dcnt_nxt = dcnt_p1;
									last_nxt = ((dcnt_r + 2'h2) == len_r);
									if (last_r) hst_nxt = H_STOP;
								end
								default:
								begin
									hst_nxt = H_STOP;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hst_r <= H_IDLE; ph_r <= HP_ADDRW; q_r <= 2'h0; bit_r <= 4'h0;
			sh_r <= 8'h00; dcnt_r <= 2'h0; last_r <= 1'b0; dv_r <= 7'h00;
			scl_oe_n_r <= 1'b1; sda_oe_n_r <= 1'b1; nack_r <= 1'b0; done_r <= 1'b0;
			rcnt_r <= 8'h00; rdat_r <= 16'h0000; op_r <= 2'h0; i2c_en_r <= 1'b0;
			len_r <= 2'h0; hidx_r <= 7'h00; wd_r <= 16'h0000;
			ack_r <= 1'b0; dat_r <= 32'h0000_0000;
		end
		else
		begin
			hst_r <= hst_nxt; ph_r <= ph_nxt; q_r <= q_nxt; bit_r <= bit_nxt;
			sh_r <= sh_nxt; dcnt_r <= dcnt_nxt; last_r <= last_nxt;
			dv_r <= (go || tick) ? 7'h00 : dv_r + 7'h01;
			scl_oe_n_r <= scl_oe_n_nxt; sda_oe_n_r <= sda_oe_n_nxt;
			nack_r <= nack_nxt; done_r <= done_nxt;
			rcnt_r <= rcnt_nxt; rdat_r <= rdat_nxt;
			ack_r <= wb_req;
			dat_r <= rd_mux;
			if (wr_ctrl && wb_sel_i[0])
			begin
				op_r <= wb_dat_i[`CCS_CTRL_OP_LSB +: 2];
				i2c_en_r <= wb_dat_i[`CCS_CTRL_I2C_EN];
				len_r <= wb_dat_i[`CCS_CTRL_LEN_LSB +: 2];
			end
			if (wr_ctrl && wb_sel_i[1]) hidx_r <= wb_dat_i[`CCS_CTRL_IDX_LSB +: 7];
			if (wr_wd && wb_sel_i[0]) wd_r[7:0] <= wb_dat_i[7:0];
			if (wr_wd && wb_sel_i[1]) wd_r[15:8] <= wb_dat_i[15:8];
		end
	end

	assign wb_ack_o       = ack_r;
	assign wb_dat_o       = dat_r;
	assign i2c_en_o       = i2c_en_r;
	assign bus.m_scl_o    = 1'b0;
	assign bus.m_sda_o    = 1'b0;
	assign bus.m_scl_oe_n = scl_oe_n_r;
	assign bus.m_sda_oe_n = sda_oe_n_r;
endmodule // ccs_host

`default_nettype wire

// ==== pkg/ccs_params.svh ====
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ****************************************
// Serial addressing
// ****************************************
`define CCS_ADDR_W        8'hd2
`define CCS_ADDR_R        8'hd3
`define CCS_CMD_BYTE_BIT  7

// ****************************************
// Control registers
// ****************************************
`define CCS_REG_A_IDX     7'h00
`define CCS_REG_B_IDX     7'h01
`define CCS_REG_A_RST     8'hff
`define CCS_REG_B_RST     8'hf6
`define CCS_REG_A_FIX_OR  8'h01
`define CCS_REG_B_FIX_AND 8'hf7
`define CCS_BLOCK_COUNT   8'h02

// ****************************************
// Host bit timing
// ****************************************
`define CCS_CLK_MHZ       25
`define CCS_SCL_QTR_NS    2500
`define CCS_SCL_QTR_CYC   ((`CCS_SCL_QTR_NS * `CCS_CLK_MHZ + 999) / 1000)

// ****************************************
// Host register map
// ****************************************
`define CCS_WB_CTRL       2'h0
`define CCS_WB_WDATA      2'h1
`define CCS_WB_STAT       2'h2
`define CCS_WB_RDATA      2'h3
`define CCS_CTRL_GO       0
`define CCS_CTRL_OP_LSB   1
`define CCS_CTRL_I2C_EN   3
`define CCS_CTRL_LEN_LSB  4
`define CCS_CTRL_IDX_LSB  8

`endif

// ==== pkg/ccs_pkg.sv ====
package ccs_pkg;

	typedef enum logic [2:0] {
		SS_IDLE  = 3'h0,
		SS_RX    = 3'h1,
		SS_RACK  = 3'h2,
		SS_TLOAD = 3'h3,
		SS_TX    = 3'h4,
		SS_TACK  = 3'h5,
		SS_WAIT  = 3'h6
	} ccs_sst_t;

	typedef enum logic [2:0] {
		SP_ADDR = 3'h0,
		SP_CMD  = 3'h1,
		SP_CNT  = 3'h2,
		SP_DATA = 3'h3,
		SP_DONE = 3'h4
	} ccs_sph_t;

	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BYTE  = 2'h2,
		H_STOP  = 2'h3
	} ccs_hst_t;

	typedef enum logic [2:0] {
		HP_ADDRW = 3'h0,
		HP_CMD   = 3'h1,
		HP_CNT   = 3'h2,
		HP_WDATA = 3'h3,
		HP_ADDRR = 3'h4,
		HP_RCNT  = 3'h5,
		HP_RDATA = 3'h6
	} ccs_hph_t;

endpackage

// ==== pkg/ccs_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface ccs_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	logic scl;
	logic sda;

	// Open-drain wires with pull-up
	assign scl = ~(~m_scl_oe_n & ~m_scl_o);
	assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

	modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
	modport slave (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

`default_nettype wire

// ==== rtl/ccs_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccs_pin_sync (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	// Pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Synchronised and one-cycle delayed levels
	output logic      scl_o,
	output logic      sda_o,
	output logic      scl_q_o,
	output logic      sda_q_o
);
	logic [1:0] meta_r;
	logic [1:0] sync_r;
	logic [1:0] dly_r;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= 2'h3;
			sync_r <= 2'h3;
			dly_r  <= 2'h3;
		end
		else
		begin
			meta_r <= {scl_i, sda_i};
			sync_r <= meta_r;
			dly_r  <= sync_r;
		end
	end

	assign scl_o   = sync_r[1];
	assign sda_o   = sync_r[0];
	assign scl_q_o = dly_r[1];
	assign sda_q_o = dly_r[0];
endmodule // ccs_pin_sync

`default_nettype wire

// ==== rtl/ccs_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"

module ccs_slave (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Serial link
	ccs_if.slave            bus,
	// Configuration
	input  wire logic       i2c_en_i,
	// Clock output enables
	output logic [7:1]      serial_ref_pair_en_o,
	output logic            free_bus_clk0_en_o,
	output logic            dot_clock_pair_en_o,
	output logic            usb_clk0_en_o,
	output logic            reference_out0_en_o,
	output logic [1:0]      proc_clk_pair_en_o,
	output logic            proc_pll_spread_en_o
);
	import ccs_pkg::*;

	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic scl_s, sda_s, scl_d, sda_d;

	ccs_pin_sync u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.scl_i   (bus.scl),
		.sda_i   (bus.sda),
		.scl_o   (scl_s),
		.sda_o   (sda_s),
		.scl_q_o (scl_d),
		.sda_q_o (sda_d)
	);

	wire scl_rise  = scl_s & ~scl_d;
	wire scl_fall  = ~scl_s & scl_d;
	wire start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	// ****************************************
	// State
	// ****************************************
	ccs_sst_t   st_r, st_nxt;
	ccs_sph_t   ph_r, ph_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [6:0] idx_r, idx_nxt;
	logic       blk_r, blk_nxt;
	logic       seen_r, seen_nxt;
	logic       oe_n_r, oe_n_nxt;
	logic       mack_r, mack_nxt;
	logic [7:0] reg_a_r, reg_a_nxt;
	logic [7:0] reg_b_r, reg_b_nxt;

	// ****************************************
	// Decode
	// ****************************************
	// Read direction only valid after a command set the index
	wire addr_hit = (sh_r == `CCS_ADDR_W) || ((sh_r == `CCS_ADDR_R) && seen_r);
	wire byte_ok  = (ph_r == SP_ADDR) ? addr_hit : (ph_r != SP_DONE);
	wire is_byte  = sh_r[`CCS_CMD_BYTE_BIT];
	wire sel_a    = (idx_r == `CCS_REG_A_IDX);
	wire sel_b    = (idx_r == `CCS_REG_B_IDX);
	// Unimplemented indices read as zero and drop writes
	wire [7:0] rd_byte = sel_a ? reg_a_r : (sel_b ? reg_b_r : 8'h00);
	wire [7:0] tx_src  = (ph_r == SP_CNT) ? `CCS_BLOCK_COUNT : rd_byte;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_nxt    = st_r;
		ph_nxt    = ph_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		idx_nxt   = idx_r;
		blk_nxt   = blk_r;
		seen_nxt  = seen_r;
		oe_n_nxt  = oe_n_r;
		mack_nxt  = mack_r;
		reg_a_nxt = reg_a_r;
		reg_b_nxt = reg_b_r;
		if (stop_det)
		begin
			// Only whole acknowledged bytes were committed
			st_nxt   = SS_IDLE;
			oe_n_nxt = 1'b1;
			seen_nxt = 1'b0;
		end
		else if (start_det)
		begin
			st_nxt   = SS_RX;
			ph_nxt   = SP_ADDR;
			cnt_nxt  = 4'h0;
			oe_n_nxt = 1'b1;
		end
		else
		begin
			unique case (st_r)
				SS_IDLE, SS_WAIT: oe_n_nxt = 1'b1;
				SS_RX:
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (scl_fall && (cnt_r == 4'h8))
					begin
						// Foreign address or surplus byte: stay off the line
						oe_n_nxt = ~byte_ok;
						st_nxt   = byte_ok ? SS_RACK : SS_WAIT;
					end
				SS_RACK:
					if (scl_fall)
					begin
						oe_n_nxt = 1'b1;
						cnt_nxt  = 4'h0;
						st_nxt   = SS_RX;
						unique case (ph_r)
							SP_ADDR:
								if (sh_r[0])
								begin
									st_nxt = SS_TLOAD;
									ph_nxt = blk_r ? SP_CNT : SP_DATA;
								end
								else
									ph_nxt = SP_CMD;
							SP_CMD:
							begin
								seen_nxt = 1'b1;
								blk_nxt  = ~is_byte;
								// Block always starts at the lowest byte
								idx_nxt  = is_byte ? sh_r[6:0] : `CCS_REG_A_IDX;
								ph_nxt   = (is_byte || i2c_en_i) ? SP_DATA : SP_CNT;
							end
							// Count is acknowledged but not needed
							SP_CNT: ph_nxt = SP_DATA;
							SP_DATA:
							begin
								// Commit only at the end of the ack bit
								if (sel_a)
									reg_a_nxt = sh_r | `CCS_REG_A_FIX_OR;
								if (sel_b)
									reg_b_nxt = sh_r & `CCS_REG_B_FIX_AND;
								idx_nxt = idx_r + 7'h01;
								if (!blk_r)
									ph_nxt = SP_DONE;
							end
							SP_DONE: st_nxt = SS_WAIT;
						endcase
					end
				SS_TLOAD:
				begin
					// Open-drain: enable low drives a zero bit
					sh_nxt   = tx_src;
					oe_n_nxt = tx_src[7];
					cnt_nxt  = 4'h1;
					st_nxt   = SS_TX;
					if (ph_r == SP_CNT)
						ph_nxt = SP_DATA;
					else
						idx_nxt = idx_r + 7'h01;
				end
				SS_TX:
					if (scl_fall && (cnt_r == 4'h8))
					begin
						oe_n_nxt = 1'b1;
						st_nxt   = SS_TACK;
					end
					else if (scl_fall)
					begin
						oe_n_nxt = sh_r[6];
						sh_nxt   = {sh_r[6:0], 1'b0};
						cnt_nxt  = cnt_r + 4'h1;
					end
				// Not-acknowledge ends the read
				SS_TACK:
					if (scl_rise)
						mack_nxt = ~sda_s;
					else if (scl_fall)
						st_nxt = mack_r ? SS_TLOAD : SS_WAIT;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r    <= SS_IDLE;
			ph_r    <= SP_ADDR;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			idx_r   <= 7'h00;
			blk_r   <= 1'b0;
			seen_r  <= 1'b0;
			oe_n_r  <= 1'b1;
			mack_r  <= 1'b0;
			reg_a_r <= `CCS_REG_A_RST;
			reg_b_r <= `CCS_REG_B_RST;
		end
		else
		begin
			st_r    <= st_nxt;
			ph_r    <= ph_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			idx_r   <= idx_nxt;
			blk_r   <= blk_nxt;
			seen_r  <= seen_nxt;
			oe_n_r  <= oe_n_nxt;
			mack_r  <= mack_nxt;
			reg_a_r <= reg_a_nxt;
			reg_b_r <= reg_b_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus.s_sda_o           = 1'b0;
	assign bus.s_sda_oe_n        = oe_n_r;
	assign serial_ref_pair_en_o  = reg_a_r[7:1];
	assign free_bus_clk0_en_o    = reg_b_r[7];
	assign dot_clock_pair_en_o   = reg_b_r[6];
	assign usb_clk0_en_o         = reg_b_r[5];
	assign reference_out0_en_o   = reg_b_r[4];
	assign proc_clk_pair_en_o    = reg_b_r[2:1];
	assign proc_pll_spread_en_o  = reg_b_r[0];
endmodule // ccs_slave

`default_nettype wire

// ==== sim/ccs_link_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccs_link_props (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	// Link wires
	input  wire logic s_sda_oe_n,
	input  wire logic scl,
	input  wire logic sda
);
	// ****************************************
	// Frame tracker on the raw wires
	// ****************************************
	logic       scl_q_r;
	logic       sda_q_r;
	logic       in_frame_r;
	logic [3:0] bit_cnt_r;
	logic [3:0] byte_no_r;
	logic [7:0] shift_r;
	logic [7:0] addr_r;
	logic [7:0] cmd_r;
	wire        rise_w     = scl & ~scl_q_r;
	wire        start_w    = scl & scl_q_r & sda_q_r & ~sda;
	wire        stop_w     = scl & scl_q_r & ~sda_q_r & sda;
	wire        ack_w      = rise_w & in_frame_r & (bit_cnt_r == 4'h8);
	wire        take_cmd_w = (byte_no_r == 4'h1) & (addr_r == 8'hd2);
	wire        take_adr_w = (byte_no_r == 4'h0);

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{scl_q_r, sda_q_r, in_frame_r} <= 3'h6;
		else
			{scl_q_r, sda_q_r, in_frame_r} <= {scl, sda, (in_frame_r | start_w) & ~stop_w};
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{bit_cnt_r, byte_no_r} <= 8'h00;
		else if (start_w)
			{bit_cnt_r, byte_no_r} <= 8'h00;
		else if (ack_w)
			{bit_cnt_r, byte_no_r} <= {4'h0, byte_no_r + 4'h1};
		else if (rise_w)
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end

	// Address and command kept until the next frame rewrites them
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{shift_r, addr_r, cmd_r} <= 24'h000000;
		else if (ack_w)
			{addr_r, cmd_r} <= {take_adr_w ? shift_r : addr_r, take_cmd_w ? shift_r : cmd_r};
		else if (rise_w)
			shift_r <= {shift_r[6:0], sda};
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_addr_match: assert property (ack_w && take_adr_w && !sda |-> shift_r[7:1] == 7'h69)
		else $error("foreign address acknowledged");
	a_addr_acked: assert property (ack_w && take_adr_w && shift_r == 8'hd2 |-> !sda)
		else $error("own write address not acknowledged");
	a_write_acked: assert property (ack_w && !take_adr_w && addr_r == 8'hd2 |-> !sda)
		else $error("written byte not acknowledged");
	a_sda_hold: assert property ($changed(s_sda_oe_n) |-> !scl && !$past(scl))
		else $error("device moved data while clock high");
	a_idle_release: assert property (!in_frame_r |-> s_sda_oe_n)
		else $error("device drives data outside a frame");
	a_addr_listen: assert property (in_frame_r && take_adr_w && bit_cnt_r < 4'h8 |-> s_sda_oe_n)
		else $error("device drives during address");
	a_write_listen: assert property (in_frame_r && addr_r == 8'hd2 && !take_adr_w
		&& bit_cnt_r != 4'h0 && bit_cnt_r < 4'h8 |-> s_sda_oe_n)
		else $error("device drives during a written byte");
	a_read_count: assert property (ack_w && byte_no_r == 4'h1 && addr_r == 8'hd3
		&& !cmd_r[7] |-> shift_r == 8'h02)
		else $error("block read count wrong");
endmodule // ccs_link_props

`default_nettype wire

// ==== sim/clock_chip_serial_config_slave_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccs_params.svh"

module clock_chip_serial_config_slave_bench;
	logic        clock_i    = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic        wb_cyc     = 1'b0;
	logic        wb_stb     = 1'b0;
	logic        wb_we      = 1'b0;
	logic [3:0]  wb_adr     = 4'h0;
	logic [3:0]  wb_sel     = 4'hf;
	logic [31:0] wb_dat     = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        i2c_en;
	logic [7:1]  src_en;
	logic        bus_en;
	logic        dot_en;
	logic        usb_en;
	logic        ref_en;
	logic        spr_en;
	logic [1:0]  cpu_en;
	logic [7:0]  m_reg [0:1];
	logic [31:0] rd;
	logic [7:0]  v0;
	logic [7:0]  v1;
	integer      num_errors = 0;
	integer      num_checks = 0;
	integer      seed       = 31;

	initial
	begin
		forever #20 clock_i = ~clock_i;
	end

	ccs_if u_ccs_if ();
	ccs_host u_ccs_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus(u_ccs_if.master), .i2c_en_o(i2c_en));
	ccs_slave u_ccs_slave (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(u_ccs_if.slave),
		.i2c_en_i(i2c_en), .serial_ref_pair_en_o(src_en), .free_bus_clk0_en_o(bus_en),
		.dot_clock_pair_en_o(dot_en), .usb_clk0_en_o(usb_en), .reference_out0_en_o(ref_en),
		.proc_clk_pair_en_o(cpu_en), .proc_pll_spread_en_o(spr_en));
	ccs_link_props u_ccs_link_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.s_sda_oe_n(u_ccs_if.s_sda_oe_n), .scl(u_ccs_if.scl), .sda(u_ccs_if.sda));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Read data taken at the edge that sees ack, never later
	task automatic wb_xfer(input logic we, input logic [1:0] word, input logic [31:0] wd);
		int n;
		@(posedge clock_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'h3, we, word, 2'h0, wd};
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		{wb_cyc, wb_stb} <= 2'h0;
		chk({31'h0, wb_ack_o}, 32'h1, "bus ack");
	endtask

	task automatic run_op(input logic [1:0] op, input logic i2c, input logic [1:0] len,
		input logic [6:0] idx, input logic [15:0] wd);
		int n;
		wb_xfer(1'b1, `CCS_WB_WDATA, {16'h0, wd});
		wb_xfer(1'b1, `CCS_WB_CTRL, {17'h0, idx, 2'h0, len, i2c, op, 1'b1});
		n = 0;
		do
		begin
			wb_xfer(1'b0, `CCS_WB_STAT, 32'h0);
			n++;
		end
		while (!(rd[2] === 1'b1 && rd[0] === 1'b0) && n < 30000);
		chk({29'h0, rd[2:0]}, 32'h4, "status after transfer");
		$display("test op %0d len %0d done", op, len);
	endtask

	task automatic chk_outs;
		chk({24'h0, src_en, 1'b1}, {24'h0, m_reg[0]}, "enables a");
		chk({24'h0, bus_en, dot_en, usb_en, ref_en, 1'b0, cpu_en, spr_en},
			{24'h0, m_reg[1]}, "enables b");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		m_reg[0] = 8'hff;
		m_reg[1] = 8'hf6;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		chk_outs();
		for (int i = 0; i < 2; i++)
		begin
			v0 = 8'($random(seed));
			m_reg[i] = (i == 0) ? (v0 | 8'h01) : (v0 & 8'hf7);
			run_op(2'h0, 1'b0, 2'h0, 7'(i), {8'h0, m_reg[i]});
			chk_outs();
		end
		run_op(2'h1, 1'b0, 2'h0, 7'h01, 16'h0);
		wb_xfer(1'b0, `CCS_WB_RDATA, 32'h0);
		chk({24'h0, rd[7:0]}, {24'h0, m_reg[1]}, "byte read");
		v0 = 8'($random(seed)) | 8'h01;
		v1 = 8'($random(seed)) & 8'hf7;
		run_op(2'h2, 1'b0, 2'h2, 7'h00, {v1, v0});
		m_reg[0] = v0;
		m_reg[1] = v1;
		chk_outs();
		v0 = 8'($random(seed)) | 8'h01;
		run_op(2'h2, 1'b1, 2'h1, 7'h00, {8'h0, v0});
		m_reg[0] = v0;
		chk_outs();
		chk({31'h0, i2c_en}, 32'h1, "count skip enable set");
		run_op(2'h3, 1'b0, 2'h2, 7'h00, 16'h0);
		wb_xfer(1'b0, `CCS_WB_RDATA, 32'h0);
		chk({8'h0, rd[23:0]}, {16'h0002, m_reg[1], m_reg[0]}, "block read");
		chk({31'h0, i2c_en}, 32'h0, "count skip enable clear");
		end_of_test();
	end

	initial
	begin
		repeat (95000) @(posedge clock_i);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule // clock_chip_serial_config_slave_bench

`default_nettype wire
